// ### verilog/dpr_pkg.sv
// Constants, register map and encodings for the dual-port RAM.
// Assumes one clock shared by the register port, both data ports and the neighbour cascade.
// Summary of operation
// - One 36Kb array, two independent ports sharing only the stored contents.
// - Array works as one 36Kb memory or as two separate 18Kb halves.
// - Data, address, enables and write enables are captured on the clock.
// - Address is held until the next operation unless latching is disabled.
// - Optional output pipeline stage adds exactly one cycle of read latency.
// - Output during a write shows old data, new data, or stays unchanged.
// - Full array ports take shapes from 32Kx1 up to 512x72.
// - Both ports choose their shapes independently, for RAM and FIFO use.
// - Each 18Kb half takes shapes from 16Kx1 up to 512x36.
// - Widths above 18 (half) or 36 (full) only in simple two-port mode.
// - In simple two-port mode the write side is one of the two widest shapes, read side variable.
// - 64-bit words store eight Hamming bits; single errors fixed, doubles flagged.
// - ECC encoder and decoder are usable for external 72-bit memories.
// - FIFO operation in 36Kb or 18Kb size.
// - FIFO advances its own addresses and drives full, empty, prog full, prog empty.
// - User sets thresholds; each programmable flag rises when the count reaches it.
// - FIFO write and read widths may differ within one instance.
// - Cascade path to a neighbouring block builds deeper memories.
// - Unused or gated arrays are held idle through the user sleep input, which blocks new operations.
// - In true dual-port mode both ports of the full array take variable widths.
package dpr_pkg;
    localparam int DATA_W = 72;
    localparam int ADDR_W = 16;
    localparam int WORDS = 512;
    localparam int WORD_AW = 9;
    localparam int LANE_W = 9;
    localparam int BYTE_W = 8;
    localparam int LANES_PER_WORD = 8;
    localparam int ECC_DATA_W = 64;
    localparam int ECC_CHK_W = 8;
    localparam int HAM_BITS = 7;
    localparam int HPOS_FIRST = 3;
    localparam int CNT_W = 13;
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_AFULL = 4'h4;
    localparam logic [3:0] REG_AEMPTY = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    localparam int CB_HALF = 0;
    localparam int CB_STP = 1;
    localparam int CB_FIFO = 2;
    localparam int CB_ECC = 3;
    localparam int CB_PIPE_A = 4;
    localparam int CB_PIPE_B = 5;
    localparam int CB_WM_A = 6;
    localparam int CB_WM_B = 8;
    localparam int CB_NOLATCH = 10;
    localparam int CB_CASC = 11;
    localparam int CB_WID_A = 12;
    localparam int CB_WID_B = 15;

    localparam int SB_FULL = 13;
    localparam int SB_EMPTY = 14;
    localparam int SB_PFULL = 15;
    localparam int SB_PEMPTY = 16;
    localparam int SB_SBIT = 17;
    localparam int SB_DBIT = 18;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [12:0] AFULL_RST = 13'h0f00;
    localparam logic [12:0] AEMPTY_RST = 13'h0010;
    localparam logic [12:0] DEPTH_FULL = 13'h1000;
    localparam logic [12:0] DEPTH_HALF = 13'h0800;
    localparam logic [11:0] LANE_MASK_FULL = 12'hfff;
    localparam logic [11:0] LANE_MASK_HALF = 12'h7ff;

    localparam logic [2:0] W_X1 = 3'h0;
    localparam logic [2:0] W_X9 = 3'h3;
    localparam logic [2:0] W_X18 = 3'h4;
    localparam logic [2:0] W_X36 = 3'h5;
    localparam logic [2:0] W_X72 = 3'h6;

    typedef enum logic [1:0] {
        WM_READ_FIRST = 2'h0,
        WM_WRITE_FIRST = 2'h1,
        WM_NO_CHANGE = 2'h2
    } dpr_wmode_t;
endpackage : dpr_pkg

// ### verilog/dpr_top.sv
// Dual-port 36Kb RAM with write modes, output pipeline, ECC and FIFO control.
// Assumes user logic, register master and cascade neighbours all run on clk.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dpr_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sleep,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic en_a,
    input wire logic we_a,
    input wire logic [15:0] addr_a,
    input wire logic [71:0] din_a,
    output logic [71:0] dout_a,
    input wire logic en_b,
    input wire logic we_b,
    input wire logic [15:0] addr_b,
    input wire logic [71:0] din_b,
    output logic [71:0] dout_b,
    input wire logic [71:0] casc_in,
    output logic [71:0] casc_out,
    output logic full,
    output logic empty,
    output logic prog_full,
    output logic prog_empty,
    output logic sbiterr,
    output logic dbiterr,
    input wire logic [63:0] enc_din,
    output logic [71:0] enc_dout,
    input wire logic [71:0] dec_din,
    output logic [63:0] dec_dout,
    output logic dec_sbiterr,
    output logic dec_dbiterr
);
    localparam int LW = dpr_pkg::LANE_W;
    localparam int BW = dpr_pkg::BYTE_W;
    localparam int NL = dpr_pkg::LANES_PER_WORD;
    localparam int DW = dpr_pkg::DATA_W;
    localparam int EW = dpr_pkg::ECC_DATA_W;
    localparam int HB = dpr_pkg::HAM_BITS;
    localparam int CW = dpr_pkg::CNT_W;

    // Check bits 0..6 cover data bits placed at non-power-of-two Hamming positions.
    function automatic logic [7:0] ecc_chk(input logic [EW-1:0] d);
        logic [7:0] c;
        int h;
        c = '0;
        h = dpr_pkg::HPOS_FIRST;
        for (int i = 0; i < EW; i++) begin
            if ((h & (h - 1)) == 0) begin
                h = h + 1;
            end
            for (int k = 0; k < HB; k++) begin
                c[k] = c[k] ^ (h[k] & d[i]);
            end
            h = h + 1;
        end
        c[HB] = ^{d, c[HB-1:0]};
        return c;
    endfunction : ecc_chk

    function automatic logic [DW-1:0] ecc_pack(input logic [EW-1:0] d);
        logic [7:0] c;
        logic [DW-1:0] w;
        c = ecc_chk(d);
        for (int l = 0; l < NL; l++) begin
            w[l*LW +: LW] = {c[l], d[l*BW +: BW]};
        end
        return w;
    endfunction : ecc_pack

    // Returns {double, single, corrected data}.
    function automatic logic [EW+1:0] ecc_fix(input logic [DW-1:0] w);
        logic [EW-1:0] d;
        logic [7:0] c;
        logic [7:0] r;
        logic [HB-1:0] s;
        logic odd;
        int h;
        for (int l = 0; l < NL; l++) begin
            d[l*BW +: BW] = w[l*LW +: BW];
            c[l] = w[l*LW + BW];
        end
        r = ecc_chk(d);
        s = r[HB-1:0] ^ c[HB-1:0];
        odd = ^w;
        h = dpr_pkg::HPOS_FIRST;
        for (int i = 0; i < EW; i++) begin
            if ((h & (h - 1)) == 0) begin
                h = h + 1;
            end
            if (odd && h[HB-1:0] == s) begin
                d[i] = ~d[i];
            end
            h = h + 1;
        end
        return {!odd && s != '0, odd, d};
    endfunction : ecc_fix

    // Maps an element address to {word, position}; position is a lane or a data bit.
    function automatic logic [14:0] locate(input logic [2:0] c, input logic [14:0] a,
                                           input logic half, input logic hid);
        logic [14:0] e;
        logic [8:0] wd;
        logic [5:0] ps;
        if (c >= dpr_pkg::W_X9) begin
            e = a << (c - dpr_pkg::W_X9);
            wd = e[11:3];
            ps = {3'h0, e[2:0]};
        end else begin
            e = a << c;
            wd = e[14:6];
            ps = e[5:0];
        end
        if (half) begin
            wd[dpr_pkg::WORD_AW-1] = hid;
        end
        return {wd, ps};
    endfunction : locate

    function automatic int elem_w(input logic [2:0] c);
        return (c >= dpr_pkg::W_X9) ? (LW << (int'(c) - 3)) : (1 << int'(c));
    endfunction : elem_w

    // Returns {mask, data} that place one element into a stored word.
    function automatic logic [2*DW-1:0] place(input logic [2:0] c, input logic [5:0] p,
                                              input logic [DW-1:0] din);
        logic [DW-1:0] m;
        logic [DW-1:0] v;
        int lo;
        m = '0;
        v = '0;
        for (int q = 0; q < DW; q++) begin
            if (c >= dpr_pkg::W_X9) begin
                lo = q - int'(p[2:0]) * LW;
            end else if (q % LW != BW) begin
                lo = (q / LW) * BW + q % LW - int'(p);
            end else begin
                lo = -1;
            end
            if (lo >= 0 && lo < elem_w(c)) begin
                m[q] = 1'b1;
                v[q] = din[lo];
            end
        end
        return {m, v};
    endfunction : place

    function automatic logic [DW-1:0] pick(input logic [2:0] c, input logic [5:0] p,
                                           input logic [DW-1:0] w);
        logic [DW-1:0] v;
        int db;
        v = '0;
        for (int o = 0; o < DW; o++) begin
            if (c >= dpr_pkg::W_X9) begin
                db = int'(p[2:0]) * LW + o;
            end else begin
                db = ((int'(p) + o) / BW) * LW + (int'(p) + o) % BW;
            end
            if (o < elem_w(c) && db < DW) begin
                v[o] = w[db];
            end
        end
        return v;
    endfunction : pick

    logic [DW-1:0] mem [dpr_pkg::WORDS];
    logic [31:0] ctrl;
    logic [12:0] afull_thr;
    logic [12:0] aempty_thr;
    logic st_sb;
    logic st_db;
    logic [31:0] next_ctrl;
    logic [12:0] next_afull_thr;
    logic [12:0] next_aempty_thr;
    logic next_st_sb;
    logic next_st_db;
    logic [31:0] next_reg_rdata;
    logic en_a_q, we_a_q, en_b_q, we_b_q;
    logic [15:0] addr_a_q, addr_b_q;
    logic [DW-1:0] din_a_q, din_b_q, casc_q;
    logic [CW-1:0] wptr, rptr, cnt;
    logic [CW-1:0] next_wptr, next_rptr, next_cnt, depth, la, lb;
    logic next_full, next_empty, next_prog_full, next_prog_empty;
    logic half, fifo, simple_two_port_mode, ecc_on, nolatch, casc_en;
    dpr_pkg::dpr_wmode_t wm_a, wm_b;
    logic [2:0] wc_a, wc_b, cap;
    logic [11:0] lane_mask;
    logic [14:0] loc_a, loc_b;
    logic [2*DW-1:0] pm_a, pm_b;
    logic [DW-1:0] old_a, new_a, old_b, new_b, base_b, rd_a, rd_b;
    logic act_a, act_b, wr_a, wr_b, load_a, load_b, push, pop, casc_sel, ecc_w, ecc_r;
    logic [EW+1:0] fix_b;
    logic [DW+1:0] s1_b, next_s1_b;
    logic [DW-1:0] s1_a, next_s1_a, next_dout_a;
    logic [DW+1:0] next_out_b;

    // Configuration decode.
    always_comb begin
        half = ctrl[dpr_pkg::CB_HALF];
        fifo = ctrl[dpr_pkg::CB_FIFO];
        simple_two_port_mode = ctrl[dpr_pkg::CB_STP] | fifo;
        ecc_on = ctrl[dpr_pkg::CB_ECC];
        nolatch = ctrl[dpr_pkg::CB_NOLATCH];
        casc_en = ctrl[dpr_pkg::CB_CASC];
        wm_a = dpr_pkg::dpr_wmode_t'(ctrl[dpr_pkg::CB_WM_A +: 2]);
        wm_b = dpr_pkg::dpr_wmode_t'(ctrl[dpr_pkg::CB_WM_B +: 2]);
        if (half) begin
            cap = simple_two_port_mode ? dpr_pkg::W_X36 : dpr_pkg::W_X18;
        end else begin
            cap = simple_two_port_mode ? dpr_pkg::W_X72 : dpr_pkg::W_X36;
        end
        wc_a = (ctrl[dpr_pkg::CB_WID_A +: 3] > cap) ? cap : ctrl[dpr_pkg::CB_WID_A +: 3];
        wc_b = (ctrl[dpr_pkg::CB_WID_B +: 3] > cap) ? cap : ctrl[dpr_pkg::CB_WID_B +: 3];
        if (simple_two_port_mode) begin
            wc_a = (wc_a == cap) ? cap : cap - 3'h1;
        end
        if (fifo && wc_b < dpr_pkg::W_X9) begin
            wc_b = dpr_pkg::W_X9;
        end
        depth = half ? dpr_pkg::DEPTH_HALF : dpr_pkg::DEPTH_FULL;
        lane_mask = half ? dpr_pkg::LANE_MASK_HALF : dpr_pkg::LANE_MASK_FULL;
        la = CW'(1) << (wc_a - dpr_pkg::W_X9);
        lb = CW'(1) << (wc_b - dpr_pkg::W_X9);
    end

    // Access stage: one cycle after capture the array is read and written.
    always_comb begin
        act_a = en_a_q;
        act_b = en_b_q;
        push = fifo & act_a & we_a_q & ~full;
        pop = fifo & act_b & ~empty;
        casc_sel = casc_en & ~fifo & addr_b_q[dpr_pkg::ADDR_W-1];
        if (fifo) begin
            loc_a = {wptr[11:3] & lane_mask[11:3], 3'h0, wptr[2:0]};
            loc_b = {rptr[11:3] & lane_mask[11:3], 3'h0, rptr[2:0]};
        end else begin
            loc_a = locate(wc_a, addr_a_q[14:0], half, 1'b0);
            loc_b = locate(wc_b, addr_b_q[14:0], half, ~simple_two_port_mode);
        end
        wr_a = fifo ? push : act_a & we_a_q;
        wr_b = act_b & we_b_q & ~simple_two_port_mode & ~casc_sel;
        ecc_w = ecc_on & simple_two_port_mode & (wc_a == dpr_pkg::W_X72);
        ecc_r = ecc_on & (wc_b == dpr_pkg::W_X72) & ~casc_sel;
        pm_a = place(wc_a, loc_a[5:0], din_a_q);
        if (ecc_w) begin
            pm_a = {{DW{1'b1}}, ecc_pack(din_a_q[EW-1:0])};
        end
        pm_b = place(wc_b, loc_b[5:0], din_b_q);
        old_a = mem[loc_a[14:6]];
        new_a = (old_a & ~pm_a[2*DW-1:DW]) | (pm_a[DW-1:0] & pm_a[2*DW-1:DW]);
        old_b = mem[loc_b[14:6]];
        base_b = (wr_a && loc_a[14:6] == loc_b[14:6]) ? new_a : old_b;
        new_b = (base_b & ~pm_b[2*DW-1:DW]) | (pm_b[DW-1:0] & pm_b[2*DW-1:DW]);
        rd_a = pick(wc_a, loc_a[5:0], (we_a_q && wm_a == dpr_pkg::WM_WRITE_FIRST) ? new_a : old_a);
        rd_b = pick(wc_b, loc_b[5:0], (wr_b && wm_b == dpr_pkg::WM_WRITE_FIRST) ? new_b : old_b);
        fix_b = ecc_fix(old_b);
        load_a = act_a & ~simple_two_port_mode & ~(we_a_q & wm_a == dpr_pkg::WM_NO_CHANGE);
        load_b = act_b & (~fifo | pop) & ~(wr_b & wm_b == dpr_pkg::WM_NO_CHANGE);
        if (casc_sel) begin
            next_s1_b = {2'h0, casc_q};
        end else if (ecc_r) begin
            next_s1_b = {fix_b[EW+1:EW], {(DW-EW){1'b0}}, fix_b[EW-1:0]};
        end else begin
            next_s1_b = {2'h0, rd_b};
        end
        next_s1_b = load_b ? next_s1_b : s1_b;
        next_s1_a = load_a ? rd_a : s1_a;
        next_dout_a = ctrl[dpr_pkg::CB_PIPE_A] ? s1_a : next_s1_a;
        next_out_b = ctrl[dpr_pkg::CB_PIPE_B] ? s1_b : next_s1_b;
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            if (wr_a) begin
                mem[loc_a[14:6]] <= new_a;
            end
            if (wr_b) begin
                mem[loc_b[14:6]] <= new_b;
            end
        end
    end

    // Output stages: s1 is the array register, the ports show it or the pipeline copy.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_a <= '0;
            s1_b <= '0;
            dout_a <= '0;
            dout_b <= '0;
            casc_out <= '0;
            sbiterr <= 1'b0;
            dbiterr <= 1'b0;
        end else if (ce) begin
            s1_a <= next_s1_a;
            s1_b <= next_s1_b;
            dout_a <= next_dout_a;
            dout_b <= next_out_b[DW-1:0];
            casc_out <= next_out_b[DW-1:0];
            sbiterr <= next_out_b[DW];
            dbiterr <= next_out_b[DW+1];
        end
    end

    // Input capture; sleep blocks new operations so the array stays idle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_a_q <= 1'b0;
            we_a_q <= 1'b0;
            en_b_q <= 1'b0;
            we_b_q <= 1'b0;
            addr_a_q <= '0;
            addr_b_q <= '0;
            din_a_q <= '0;
            din_b_q <= '0;
            casc_q <= '0;
        end else if (ce) begin
            en_a_q <= en_a & ~sleep;
            we_a_q <= we_a & en_a & ~sleep;
            en_b_q <= en_b & ~sleep;
            we_b_q <= we_b & en_b & ~sleep;
            addr_a_q <= (en_a | nolatch) ? addr_a : addr_a_q;
            addr_b_q <= (en_b | nolatch) ? addr_b : addr_b_q;
            din_a_q <= din_a;
            din_b_q <= din_b;
            casc_q <= casc_in;
        end
    end

    // FIFO pointers count 9-bit lanes so unequal port widths share one count.
    always_comb begin
        next_wptr = fifo ? wptr + (push ? la : CW'(0)) : '0;
        next_rptr = fifo ? rptr + (pop ? lb : CW'(0)) : '0;
        next_cnt = next_wptr - next_rptr;
        next_full = (next_cnt + la) > depth;
        next_empty = next_cnt < lb;
        next_prog_full = next_cnt >= afull_thr;
        next_prog_empty = next_cnt <= aempty_thr;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            full <= 1'b0;
            empty <= 1'b1;
            prog_full <= 1'b0;
            prog_empty <= 1'b1;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
            full <= next_full;
            empty <= next_empty;
            prog_full <= next_prog_full;
            prog_empty <= next_prog_empty;
        end
    end

    // Register port; a new error wins over a clear in the same cycle.
    always_comb begin
        next_ctrl = ctrl;
        next_afull_thr = afull_thr;
        next_aempty_thr = aempty_thr;
        next_st_sb = st_sb;
        next_st_db = st_db;
        if (reg_wr) begin
            case (reg_addr)
                dpr_pkg::REG_CTRL: next_ctrl = reg_wdata;
                dpr_pkg::REG_AFULL: next_afull_thr = reg_wdata[CW-1:0];
                dpr_pkg::REG_AEMPTY: next_aempty_thr = reg_wdata[CW-1:0];
                dpr_pkg::REG_STATUS: begin
                    next_st_sb = st_sb & ~reg_wdata[dpr_pkg::SB_SBIT];
                    next_st_db = st_db & ~reg_wdata[dpr_pkg::SB_DBIT];
                end
                default: next_ctrl = ctrl;
            endcase
        end
        next_st_sb = next_st_sb | (load_b & ecc_r & fix_b[EW]);
        next_st_db = next_st_db | (load_b & ecc_r & fix_b[EW+1]);
        next_reg_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                dpr_pkg::REG_CTRL: next_reg_rdata = ctrl;
                dpr_pkg::REG_AFULL: next_reg_rdata[CW-1:0] = afull_thr;
                dpr_pkg::REG_AEMPTY: next_reg_rdata[CW-1:0] = aempty_thr;
                dpr_pkg::REG_STATUS: begin
                    next_reg_rdata[CW-1:0] = cnt;
                    next_reg_rdata[dpr_pkg::SB_FULL] = full;
                    next_reg_rdata[dpr_pkg::SB_EMPTY] = empty;
                    next_reg_rdata[dpr_pkg::SB_PFULL] = prog_full;
                    next_reg_rdata[dpr_pkg::SB_PEMPTY] = prog_empty;
                    next_reg_rdata[dpr_pkg::SB_SBIT] = st_sb;
                    next_reg_rdata[dpr_pkg::SB_DBIT] = st_db;
                end
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= dpr_pkg::CTRL_RST;
            afull_thr <= dpr_pkg::AFULL_RST;
            aempty_thr <= dpr_pkg::AEMPTY_RST;
            st_sb <= 1'b0;
            st_db <= 1'b0;
            reg_rdata <= '0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            afull_thr <= next_afull_thr;
            aempty_thr <= next_aempty_thr;
            st_sb <= next_st_sb;
            st_db <= next_st_db;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Stand-alone codec for external wide memories, one cycle of latency.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enc_dout <= '0;
            dec_dout <= '0;
            dec_sbiterr <= 1'b0;
            dec_dbiterr <= 1'b0;
        end else if (ce) begin
            enc_dout <= ecc_pack(enc_din);
            {dec_dbiterr, dec_sbiterr, dec_dout} <= ecc_fix(dec_din);
        end
    end
endmodule : dpr_top

// ### dv/dpr_top_properties.sv
// Port assertions for the dual-port RAM top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dpr_top_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic sleep,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [71:0] dout_a,
    input wire logic [71:0] dout_b,
    input wire logic [71:0] casc_out,
    input wire logic full,
    input wire logic empty,
    input wire logic prog_full,
    input wire logic prog_empty,
    input wire logic [63:0] enc_din,
    input wire logic [71:0] enc_dout,
    input wire logic [71:0] dec_din,
    input wire logic [63:0] dec_dout,
    input wire logic dec_sbiterr,
    input wire logic dec_dbiterr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [63:0] enc_data;
    logic [71:0] flip;
    logic [1:0] live = 2'h0;
    assign flip = dec_din ^ enc_dout;
    always_comb begin
        for (int l = 0; l < 8; l++) begin
            enc_data[8*l+:8] = enc_dout[9*l+:8];
        end
    end
    // Marks edges that ran out of reset with the clock enabled.
    always_ff @(posedge clk) begin
        live <= rst_b ? {live[0], ce} : 2'h0;
    end
    a_reset_flags: assert property (!$past(rst_b) |-> empty && prog_empty && !full && !prog_full)
        else $error("flags differ from reset levels");
    a_rdata_idle: assert property (live[0] && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("register data without a read");
    a_casc_mirror: assert property (casc_out == dout_b)
        else $error("cascade output differs from port B");
    a_flag_excl: assert property (!(full && empty))
        else $error("full and empty together");
    a_enc_data: assert property (live[0] |-> enc_data == $past(enc_din))
        else $error("encoder data lanes wrong");
    a_dec_clean: assert property (live == 2'h3 && $past(flip) == 72'h0
        |-> dec_dout == $past(enc_din, 2) && !dec_sbiterr && !dec_dbiterr)
        else $error("clean word not passed");
    a_dec_single: assert property (live == 2'h3 && $past(flip) == 72'h1
        |-> dec_dout == $past(enc_din, 2) && dec_sbiterr && !dec_dbiterr)
        else $error("single error not corrected");
    a_dec_double: assert property (live == 2'h3 && $past(flip) == 72'h3
        |-> dec_dbiterr && !dec_sbiterr)
        else $error("double error not flagged");
    a_sleep_hold: assert property (sleep [*4] |-> $stable(dout_a) && $stable(dout_b))
        else $error("output moved while gated");
    c_full: cover property (full);
    c_prog_full: cover property (prog_full && !full);
    c_dec_single: cover property (dec_sbiterr);
endmodule : dpr_top_properties

// ### dv/dpr_fabric.sv
// User fabric model driving port B of the dual-port RAM.
// Assumes the caller runs its tasks from the clock domain of clk.
`timescale 1ns/1ps
module dpr_fabric (
    input wire logic clk,
    output logic en_b = 1'b0,
    output logic we_b = 1'b0,
    output logic [15:0] addr_b = 16'h0,
    output logic [71:0] din_b = 72'h0
);
    // One operation per call; calls may follow each other with no gap.
    task automatic op(input logic w, input logic [15:0] a, input logic [71:0] d);
        @(posedge clk);
        en_b <= 1'b1;
        we_b <= w;
        addr_b <= a;
        din_b <= d;
    endtask : op
    // Released lines show the inverse so stale values are never trusted.
    task automatic rest();
        @(posedge clk);
        en_b <= 1'b0;
        we_b <= 1'b0;
        addr_b <= ~addr_b;
        din_b <= ~din_b;
    endtask : rest
endmodule : dpr_fabric

// ### dv/dpr_top_bench.sv
// Self-checking bench for the dual-port RAM top.
// Assumes port B is driven by the fabric model, all else from here.
`timescale 1ns/1ps
module dpr_top_bench;
    logic clk, rst_b, ce, sleep, reg_wr, reg_rd, en_a, we_a, en_b, we_b, rsh = 1'b0;
    logic full, empty, prog_full, prog_empty, sbiterr, dbiterr, dec_sbiterr, dec_dbiterr;
    logic [3:0] reg_addr;
    logic [15:0] addr_a, addr_b;
    logic [31:0] reg_wdata, reg_rdata, rng = 32'h92c2;
    logic [71:0] din_a, din_b, dout_a, dout_b, casc_in, casc_out, enc_dout, dec_din, x;
    logic [63:0] enc_din, dec_dout;
    logic [1:0] fl;
    logic [2:0] bsh = 3'h0;
    logic [71:0] m[4] = '{default: 72'h0};
    logic [71:0] bq[$];
    logic [31:0] rq[$];
    int n_mismatch = 0, compares = 0, lat = 2, i, p;
    assign dec_din = enc_dout ^ {70'h0, fl};
    dpr_top dut (.*);
    dpr_fabric fab (.clk, .en_b, .we_b, .addr_b, .din_b);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic rw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : rw
    task automatic rr(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rr
    task automatic wa(input logic [15:0] a, input logic [71:0] d);
        @(posedge clk);
        en_a <= 1'b1;
        we_a <= 1'b1;
        addr_a <= a;
        din_a <= d;
        @(posedge clk);
        en_a <= 1'b0;
        din_a <= ~d;
    endtask : wa
    task automatic bo(input logic w, input logic [15:0] a, input logic [71:0] d, e);
        fab.op(w, a, d);
        bq.push_back(e);
    endtask : bo
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rng <= xs(rng);
        enc_din <= {rng, ~rng};
        casc_in <= {8'h0, rng, rng};
        fl <= rng[1:0];
        bsh <= {bsh[1:0], en_b & ~sleep};
        rsh <= reg_rd;
        if (rsh) chk("reg_rdata", {40'h0, rq.pop_front()}, {40'h0, reg_rdata});
        if (bsh[lat-1]) chk("dout_b", bq.pop_front(), dout_b);
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        {rst_b, sleep, reg_wr, reg_rd, en_a, we_a, reg_addr, addr_a, reg_wdata, din_a} = '0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rr(dpr_pkg::REG_CTRL, dpr_pkg::CTRL_RST);
        rr(dpr_pkg::REG_AFULL, {19'h0, dpr_pkg::AFULL_RST});
        rr(dpr_pkg::REG_AEMPTY, {19'h0, dpr_pkg::AEMPTY_RST});
        rr(dpr_pkg::REG_STATUS, 32'h0001_4000);
        rr(4'h2, 32'h0);
        rw(dpr_pkg::REG_CTRL, {14'h0, dpr_pkg::W_X36, dpr_pkg::W_X9, 12'h0});
        for (i = 0; i < 16; i++) begin
            x = {63'h0, rng[8:0]};
            wa(i[15:0], x);
            m[i/4][9*(i%4)+:9] = x[8:0];
        end
        for (p = 0; p < 2; p++) begin
            rw(dpr_pkg::REG_CTRL, {14'h0, dpr_pkg::W_X36, dpr_pkg::W_X9, 6'h0, !p[0], 5'h0});
            lat = 3 - p;
            for (i = 0; i < 4; i++) bo(1'b0, i[15:0], 72'h0, m[i]);
            fab.rest();
            repeat (4) @(posedge clk);
        end
        for (p = 0; p < 3; p++) begin
            rw(dpr_pkg::REG_CTRL, {14'h0, dpr_pkg::W_X36, dpr_pkg::W_X9, 2'h0, p[1:0], 8'h0});
            x = {36'h0, rng, rng[3:0]};
            bo(1'b0, 16'h1, 72'h0, m[1]);
            bo(1'b1, 16'h0, x, p == 0 ? m[0] : p == 1 ? x : m[1]);
            fab.rest();
            m[0] = x;
            repeat (4) @(posedge clk);
        end
        sleep <= 1'b1;
        wa(16'h0, 72'h1ff);
        wa(16'h1, 72'h0);
        sleep <= 1'b0;
        bo(1'b0, 16'h0, 72'h0, m[0]);
        fab.rest();
        wa(16'h0, 72'h0);
        rw(dpr_pkg::REG_AFULL, 32'h10);
        chk("dout_a", {63'h0, m[0][8:0]}, dout_a);
        rw(dpr_pkg::REG_AEMPTY, 32'h8);
        rw(dpr_pkg::REG_CTRL, {14'h0, dpr_pkg::W_X9, dpr_pkg::W_X72, 12'h004});
        for (i = 0; i < 3; i++) begin
            m[i] = {rng, rng, rng[7:0]};
            wa(16'h0, m[i]);
        end
        repeat (4) @(posedge clk);
        rr(dpr_pkg::REG_STATUS, 32'h0000_8018);
        for (i = 0; i < 24; i++) bo(1'b0, 16'h0, 72'h0, {63'h0, m[i/8][9*(i%8)+:9]});
        fab.rest();
        repeat (4) @(posedge clk);
        rr(dpr_pkg::REG_STATUS, 32'h0001_4000);
        for (i = 0; i < 512; i++) wa(16'h0, {rng, rng, rng[7:0]});
        repeat (4) @(posedge clk);
        rr(dpr_pkg::REG_STATUS, 32'h0000_b000);
        wa(16'h0, 72'h0);
        repeat (4) @(posedge clk);
        rr(dpr_pkg::REG_STATUS, 32'h0000_b000);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule : dpr_top_bench
bind dpr_top dpr_top_properties props (.*);
